// ===== npse_pkg.sv
// Shared constants and types for the program-suspend and erase sequencer
`default_nettype none
package npse_pkg;
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Busy times, in their own units
  localparam int unsigned T_PSPD_NS = 20000;
  localparam int unsigned T_PSPDN_NS = 5000;
  localparam int unsigned T_DBSY_NS = 1000;
  localparam int unsigned T_CBSY_NS = 3000;
  localparam int unsigned T_PROG_US = 1300;
  localparam int unsigned T_BERS_US = 15000;
  // Short times round down, never below one cycle
  localparam int unsigned PSPD_CYC = (T_PSPD_NS / CLK_PERIOD_NS) > 0 ?
                                     (T_PSPD_NS / CLK_PERIOD_NS) : 1;
  localparam int unsigned PSPDN_CYC = (T_PSPDN_NS / CLK_PERIOD_NS) > 0 ?
                                      (T_PSPDN_NS / CLK_PERIOD_NS) : 1;
  localparam int unsigned DBSY_CYC = (T_DBSY_NS / CLK_PERIOD_NS) > 0 ?
                                     (T_DBSY_NS / CLK_PERIOD_NS) : 1;
  localparam int unsigned CBSY_CYC = (T_CBSY_NS / CLK_PERIOD_NS) > 0 ?
                                     (T_CBSY_NS / CLK_PERIOD_NS) : 1;
  localparam int unsigned PROG_CYC_DFLT = T_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BERS_CYC_DFLT = T_BERS_US * 1000 / CLK_PERIOD_NS;
  // Command codes
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_ALT = 8'h81;
  localparam logic [7:0] CMD_CHG = 8'h85;
  localparam logic [7:0] CMD_CONF = 8'h10;
  localparam logic [7:0] CMD_MPLANE = 8'h11;
  localparam logic [7:0] CMD_CACHE = 8'h15;
  localparam logic [7:0] CMD_SUSP = 8'h84;
  localparam logic [7:0] CMD_RES = 8'h13;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_ERASE_Q = 8'hd1;
  localparam logic [7:0] CMD_RST_A = 8'hff;
  localparam logic [7:0] CMD_RST_B = 8'hfc;
  localparam logic [7:0] CMD_RST_C = 8'hfa;
  localparam logic [7:0] CMD_RST_D = 8'hfd;
  // Address cycle counts and where the row address starts
  localparam logic [2:0] ADDR_CYC_LONG = 3'd5;
  localparam logic [2:0] ADDR_CYC_ROW = 3'd3;
  localparam logic [2:0] ROW_FIRST_LONG = 3'd2;
  // Status byte fields
  localparam int unsigned SR_FAIL = 0;
  localparam int unsigned SR_SUSP = 2;
  localparam int unsigned SR_ARDY = 5;
  localparam int unsigned SR_RDY = 6;
  localparam int unsigned SR_LOCK = 7;
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] PLANE_OFS = 8'h08;
  localparam int unsigned CTRL_OTP = 0;
  localparam int unsigned CTRL_FAILINJ = 1;
  localparam int unsigned CTRL_ESUSP = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Command, address and LUN match of one interface cycle
  typedef struct packed {
    logic cmd_we;
    logic addr_we;
    logic [7:0] data;
    logic lun_hit;
  } npse_bus_t;
  typedef enum {SQ_IDLE, SQ_ADDR, SQ_CONF} npse_seq_t;
  typedef enum {CK_PROG, CK_COPY, CK_SUSP, CK_RES, CK_ERASE} npse_kind_t;
endpackage
`default_nettype wire

// ===== npse_seq.sv
// Per-LUN program suspend/resume and block erase sequencer with AXI4-Lite registers
// How it works
// R1: 81h opens a program exactly like 80h, closed by 10h, 11h or 15h.
// R2: Suspend pauses a running program, whether RDY is low or high.
// R3: Suspend with no program running is ignored with no busy time.
// R4: Multi-plane program pauses on all planes after some forward progress.
// R5: Suspend bit valid from ARDY rise until resume or reset.
// R6: Fail bit valid from ARDY rise until ARDY falls again.
// R7: Suspend/fail encode passed, failed, suspended; fail clears when suspended.
// R8: Suspend takes five address cycles; only the LUN match is used.
// R9: A program started during an erase suspend cannot be suspended.
// R10: Resume with five address cycles on the suspended LUN restarts the program.
// R11: Any reset command cancels a suspended program and clears its status.
// R12: While suspended, erase and program are refused; other commands pass.
// R13: Host sends no cache read or long read retry while suspended.
// R14: Program while suspended: short busy, lock bit cleared, suspension kept.
// R15: Program aimed at another LUN runs there; suspension here stays.
// R16: Reads during suspend run normally and leave the suspension alone.
// R17: Resume with nothing running or suspended gives only the short busy.
// R18: Suspend when already suspended gives the short busy, nothing else.
// R19: Suspend during cache program waits for the array page to finish.
// R20: Suspend is refused in one-time-programmable mode.
// R21: 60h, three row cycles, D0h erases one block while busy for erase time.
// R22: Host polls ready or single-LUN status, then checks fail.
// R23: 60h-row-D1h queues a plane block with short busy; D0h erases all.
// R24: Program and erase suspension are kept per LUN to steer acceptance.
`default_nettype none
module npse_seq import npse_pkg::*; #(
  parameter int unsigned PROG_CYC = PROG_CYC_DFLT,
  parameter int unsigned BERS_CYC = BERS_CYC_DFLT,
  parameter int unsigned PLANES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Interface cycles
  input wire npse_bus_t bus,
  // LUN state
  output logic rdy_o,
  output logic ardy_o,
  output logic [7:0] status_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam int unsigned PW = $clog2(PLANES);

  if (PLANES != 2 && PLANES != 4 && PLANES != 8) begin : g_bad_planes
    $error("PLANES must be 2, 4 or 8");
  end
  if (PROG_CYC < 2 || BERS_CYC < 2) begin : g_bad_times
    $error("array times too short");
  end

  function automatic logic is_reset(input logic [7:0] c);
    return c == CMD_RST_A || c == CMD_RST_B || c == CMD_RST_C || c == CMD_RST_D;
  endfunction

  // Sequencer state
  npse_seq_t sq_reg, sq_next;
  npse_kind_t kind_reg, kind_next;
  logic [2:0] acnt_reg, acnt_next;
  logic hit_reg, hit_next;
  logic [PW-1:0] plane_reg, plane_next;
  logic [PLANES-1:0] qmask_reg, qmask_next, emask_reg, emask_next;
  logic [31:0] arr_cnt_reg, arr_cnt_next, rem_reg, rem_next, short_reg, short_next;
  logic arr_busy_reg, arr_busy_next, arr_erase_reg, arr_erase_next;
  logic cache_reg, cache_next, cnext_reg, cnext_next, spend_reg, spend_next;
  logic psusp_reg, psusp_next, nosusp_reg, nosusp_next; // R24
  logic fail_reg, fail_next, susp_reg, susp_next, lock_reg, lock_next;
  logic rdy_reg, rdy_next, ardy_reg, ardy_next;
  logic [2:0] ctrl_reg;
  logic [2:0] need, row_first;
  logic last_addr, act_susp, act_res, conf_prog, start_erase;

  assign need = (kind_reg == CK_ERASE) ? ADDR_CYC_ROW : ADDR_CYC_LONG; // R8
  assign row_first = (kind_reg == CK_ERASE) ? 3'd0 : ROW_FIRST_LONG;
  assign last_addr = bus.addr_we && sq_reg == SQ_ADDR && acnt_reg + 3'd1 == need;
  assign act_susp = last_addr && kind_reg == CK_SUSP && bus.lun_hit;
  assign act_res = last_addr && kind_reg == CK_RES && bus.lun_hit;
  assign conf_prog = bus.cmd_we && rdy_reg && sq_reg == SQ_CONF && hit_reg &&
                     (kind_reg == CK_PROG || kind_reg == CK_COPY) &&
                     (bus.data == CMD_CONF || bus.data == CMD_CACHE);
  assign start_erase = bus.cmd_we && rdy_reg && ardy_reg && sq_reg == SQ_CONF && hit_reg &&
                       kind_reg == CK_ERASE && bus.data == CMD_ERASE_GO && !psusp_reg;

  always_comb begin
    sq_next = sq_reg;
    kind_next = kind_reg;
    acnt_next = acnt_reg;
    hit_next = hit_reg;
    plane_next = plane_reg;
    qmask_next = qmask_reg;
    emask_next = emask_reg;
    arr_cnt_next = arr_cnt_reg;
    rem_next = rem_reg;
    short_next = short_reg;
    arr_busy_next = arr_busy_reg;
    arr_erase_next = arr_erase_reg;
    cache_next = cache_reg;
    cnext_next = cnext_reg;
    spend_next = spend_reg;
    psusp_next = psusp_reg;
    nosusp_next = nosusp_reg;
    fail_next = fail_reg;
    susp_next = susp_reg;
    lock_next = lock_reg;
    // One countdown serves every plane, so all planes pause together
    if (arr_busy_reg) begin // R4
      arr_cnt_next = arr_cnt_reg - 32'd1;
      if (arr_cnt_reg == 32'd1) begin
        if (cache_reg && cnext_reg && spend_reg) begin // R19
          arr_busy_next = 1'b0;
          psusp_next = 1'b1;
          rem_next = 32'(PROG_CYC);
          susp_next = 1'b1;
          fail_next = 1'b0;
          spend_next = 1'b0;
          cnext_next = 1'b0;
        end else if (cache_reg && cnext_reg) begin
          arr_cnt_next = 32'(PROG_CYC);
          cnext_next = 1'b0;
        end else begin
          arr_busy_next = 1'b0;
          cache_next = 1'b0;
          spend_next = 1'b0;
          short_next = 32'd0;
          susp_next = 1'b0; // R7
          fail_next = ctrl_reg[CTRL_FAILINJ]; // R6
        end
      end
    end
    if (short_reg != 32'd0) begin
      short_next = short_reg - 32'd1;
      if (short_reg == 32'd1 && spend_next && !cache_reg) begin // R2
        psusp_next = 1'b1;
        rem_next = arr_cnt_next;
        arr_busy_next = 1'b0;
        susp_next = 1'b1; // R5
        fail_next = 1'b0; // R7
        spend_next = 1'b0;
      end
    end
    if (bus.cmd_we && is_reset(bus.data)) begin // R11
      sq_next = SQ_IDLE;
      short_next = 32'd0;
      arr_busy_next = 1'b0;
      cache_next = 1'b0;
      cnext_next = 1'b0;
      spend_next = 1'b0;
      psusp_next = 1'b0;
      susp_next = 1'b0;
      fail_next = 1'b0;
      lock_next = 1'b1;
      qmask_next = '0;
    end else if (bus.cmd_we && bus.data == CMD_SUSP) begin
      sq_next = SQ_ADDR;
      kind_next = CK_SUSP;
      acnt_next = 3'd0;
    end else if (bus.cmd_we && rdy_reg) begin
      sq_next = SQ_IDLE;
      case (bus.data)
        CMD_PROG, CMD_PROG_ALT: begin // R1
          sq_next = SQ_ADDR;
          kind_next = CK_PROG;
          acnt_next = 3'd0;
        end
        CMD_CHG: begin
          sq_next = SQ_ADDR;
          acnt_next = 3'd0;
          if (!(sq_reg == SQ_CONF && kind_reg == CK_PROG)) begin
            kind_next = CK_COPY;
          end
        end
        CMD_RES: begin
          sq_next = SQ_ADDR;
          kind_next = CK_RES;
          acnt_next = 3'd0;
        end
        CMD_ERASE: begin
          // 60h-60h-D0h queues the first block without a busy time
          if (sq_reg == SQ_CONF && kind_reg == CK_ERASE && hit_reg && !psusp_reg) begin
            qmask_next = qmask_reg | PLANES'(1) << plane_reg;
          end
          sq_next = SQ_ADDR;
          kind_next = CK_ERASE;
          acnt_next = 3'd0;
        end
        CMD_CONF, CMD_CACHE, CMD_MPLANE: begin
          if (sq_reg == SQ_CONF && hit_reg && kind_reg != CK_ERASE) begin
            if (psusp_reg) begin // R14
              short_next = 32'(PSPDN_CYC);
              lock_next = 1'b0;
            end else if (bus.data == CMD_MPLANE) begin
              short_next = 32'(DBSY_CYC);
            end else if (arr_busy_reg && cache_reg) begin
              cnext_next = 1'b1;
              short_next = 32'(CBSY_CYC);
            end else begin
              arr_busy_next = 1'b1;
              arr_erase_next = 1'b0;
              arr_cnt_next = 32'(PROG_CYC);
              cache_next = bus.data == CMD_CACHE;
              short_next = (bus.data == CMD_CACHE) ? 32'(CBSY_CYC) : 32'd0;
              nosusp_next = ctrl_reg[CTRL_ESUSP]; // R9
              fail_next = 1'b0; // R6
              susp_next = 1'b0;
              lock_next = 1'b1;
            end
          end
        end
        CMD_ERASE_GO, CMD_ERASE_Q: begin
          // Not while a cache program still owns the array
          if (sq_reg == SQ_CONF && hit_reg && kind_reg == CK_ERASE && ardy_reg) begin // R21
            if (psusp_reg) begin // R12
              short_next = 32'(PSPDN_CYC);
              lock_next = 1'b0;
            end else if (bus.data == CMD_ERASE_Q) begin // R23
              qmask_next = qmask_reg | PLANES'(1) << plane_reg;
              short_next = 32'(DBSY_CYC);
            end else begin // R21
              emask_next = qmask_reg | PLANES'(1) << plane_reg;
              qmask_next = '0;
              arr_busy_next = 1'b1;
              arr_erase_next = 1'b1;
              arr_cnt_next = 32'(BERS_CYC);
              fail_next = 1'b0;
              susp_next = 1'b0;
              lock_next = 1'b1;
            end
          end
        end
        // Reads, status and feature commands pass untouched
        default: begin // R16
          sq_next = SQ_IDLE;
        end
      endcase
    end
    if (bus.addr_we && sq_reg == SQ_ADDR) begin
      acnt_next = acnt_reg + 3'd1;
      hit_next = bus.lun_hit; // R15
      if (acnt_reg == row_first) begin
        plane_next = bus.data[PW-1:0];
      end
      if (last_addr) begin
        sq_next = (kind_reg == CK_SUSP || kind_reg == CK_RES) ? SQ_IDLE : SQ_CONF;
      end
    end
    if (act_susp) begin
      if (psusp_reg) begin // R18
        short_next = 32'(PSPDN_CYC);
      end else if (arr_busy_reg && !arr_erase_reg && !nosusp_reg &&
                   !ctrl_reg[CTRL_OTP] && !spend_reg) begin // R20
        spend_next = 1'b1;
        short_next = cache_reg ? 32'd0 : 32'(PSPD_CYC);
      end
      // Otherwise nothing: no busy time at all R3
    end
    if (act_res) begin
      if (psusp_reg) begin // R10
        psusp_next = 1'b0;
        susp_next = 1'b0;
        fail_next = 1'b0;
        arr_busy_next = 1'b1;
        arr_erase_next = 1'b0;
        arr_cnt_next = rem_reg;
      end else if (!arr_busy_reg) begin // R17
        short_next = 32'(PSPDN_CYC);
      end
    end
    // Cache program keeps RDY high while the array works
    ardy_next = short_next == 32'd0 && !arr_busy_next;
    rdy_next = short_next == 32'd0 && !spend_next && !(arr_busy_next && !cache_next);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sq_reg <= SQ_IDLE;
      kind_reg <= CK_PROG;
      acnt_reg <= 3'd0;
      hit_reg <= 1'b0;
      plane_reg <= '0;
      qmask_reg <= '0;
      emask_reg <= '0;
      arr_cnt_reg <= 32'd0;
      rem_reg <= 32'd0;
      short_reg <= 32'd0;
      arr_busy_reg <= 1'b0;
      arr_erase_reg <= 1'b0;
      cache_reg <= 1'b0;
      cnext_reg <= 1'b0;
      spend_reg <= 1'b0;
      psusp_reg <= 1'b0;
      nosusp_reg <= 1'b0;
      fail_reg <= 1'b0;
      susp_reg <= 1'b0;
      lock_reg <= 1'b1;
      rdy_reg <= 1'b1;
      ardy_reg <= 1'b1;
      status_o <= 8'he0;
    end else begin
      sq_reg <= sq_next;
      kind_reg <= kind_next;
      acnt_reg <= acnt_next;
      hit_reg <= hit_next;
      plane_reg <= plane_next;
      qmask_reg <= qmask_next;
      emask_reg <= emask_next;
      arr_cnt_reg <= arr_cnt_next;
      rem_reg <= rem_next;
      short_reg <= short_next;
      arr_busy_reg <= arr_busy_next;
      arr_erase_reg <= arr_erase_next;
      cache_reg <= cache_next;
      cnext_reg <= cnext_next;
      spend_reg <= spend_next;
      psusp_reg <= psusp_next;
      nosusp_reg <= nosusp_next;
      fail_reg <= fail_next;
      susp_reg <= susp_next;
      lock_reg <= lock_next;
      rdy_reg <= rdy_next;
      ardy_reg <= ardy_next;
      status_o <= {lock_next, rdy_next, ardy_next, 2'b00, susp_next, 1'b0, fail_next};
    end
  end
  assign rdy_o = rdy_reg;
  assign ardy_o = ardy_reg;

  // AXI4-Lite slave
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rdata_next;
  logic ws_reg, ws_next;
  logic [2:0] ctrl_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    ctrl_next = ctrl_reg;
    bvalid_next = s_bvalid && !s_bready;
    bresp_next = s_bresp;
    rvalid_next = s_rvalid && !s_rready;
    rresp_next = s_rresp;
    rdata_next = s_rdata;
    if (s_awvalid && s_awready) begin
      aw_full_next = 1'b1;
      awa_next = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_full_next = 1'b1;
      wd_next = s_wdata;
      ws_next = s_wstrb[0];
    end
    if (aw_full_reg && w_full_reg && !s_bvalid) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (awa_reg == CTRL_OFS) begin
        if (ws_reg) begin
          ctrl_next = wd_reg[2:0];
        end
      end else if (awa_reg != STAT_OFS && awa_reg != PLANE_OFS) begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (s_arvalid && s_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_araddr)
        CTRL_OFS: rdata_next = {29'h0, ctrl_reg};
        STAT_OFS: rdata_next = {20'h0, psusp_reg, spend_reg, cache_reg, arr_erase_reg,
                                status_o};
        PLANE_OFS: rdata_next = {16'h0, 8'(emask_reg), 8'(qmask_reg)};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_full_next;
    wready_next = !w_full_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awa_reg <= 8'h0;
      wd_reg <= 32'h0;
      ws_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_arready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rresp <= RESP_OKAY;
      s_rdata <= 32'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      ctrl_reg <= ctrl_next;
      s_awready <= awready_next;
      s_wready <= wready_next;
      s_arready <= arready_next;
      s_bvalid <= bvalid_next;
      s_bresp <= bresp_next;
      s_rvalid <= rvalid_next;
      s_rresp <= rresp_next;
      s_rdata <= rdata_next;
    end
  end

  // Checks
  lock_reject_a: assert property (@(posedge clk) disable iff (rst) // R14
    conf_prog && psusp_reg && !act_susp |=> !status_o[SR_LOCK] && !rdy_reg && psusp_reg)
    else $error("program during suspend not refused");
  susp_ignore_a: assert property (@(posedge clk) disable iff (rst) // R3
    act_susp && !arr_busy_reg && !psusp_reg |=> short_reg == 32'd0 && !spend_reg)
    else $error("idle suspend produced busy");
  susp_code_a: assert property (@(posedge clk) disable iff (rst) // R7
    status_o[SR_SUSP] |-> !status_o[SR_FAIL] && psusp_reg)
    else $error("reserved suspend code shown");
  susp_valid_a: assert property (@(posedge clk) disable iff (rst) // R5
    $rose(psusp_reg) |-> $rose(ardy_reg) && status_o[SR_SUSP])
    else $error("suspend bit not valid at ARDY rise");
  resusp_busy_a: assert property (@(posedge clk) disable iff (rst) // R18
    act_susp && psusp_reg && !bus.cmd_we |=> short_reg == 32'(PSPDN_CYC) && psusp_reg)
    else $error("repeat suspend wrong");
  nosusp_esusp_a: assert property (@(posedge clk) disable iff (rst) // R9
    act_susp && nosusp_reg && !psusp_reg |=> !spend_reg && !psusp_reg)
    else $error("program suspended under erase suspend");
  otp_nosusp_a: assert property (@(posedge clk) disable iff (rst) // R20
    act_susp && ctrl_reg[CTRL_OTP] && !psusp_reg |=> !spend_reg ##1 !psusp_reg)
    else $error("suspend in OTP mode");
  reset_cancel_a: assert property (@(posedge clk) disable iff (rst) // R11
    bus.cmd_we && is_reset(bus.data) |=> !psusp_reg && !status_o[SR_SUSP] && rdy_reg)
    else $error("reset left suspension");
  erase_start_a: assert property (@(posedge clk) disable iff (rst) // R21
    start_erase && !act_susp |=> !ardy_reg && arr_erase_reg && arr_cnt_reg == 32'(BERS_CYC))
    else $error("erase did not start");
  resume_go_a: assert property (@(posedge clk) disable iff (rst) // R10
    act_res && psusp_reg |=> arr_busy_reg && !psusp_reg && !status_o[SR_SUSP])
    else $error("resume did not restart program");
endmodule
`default_nettype wire

// ===== npse_host.sv
// Host controller model issuing command and address cycles
`default_nettype none
module npse_host import npse_pkg::*; (
  // Clock
  input wire logic clk,
  // Interface cycles
  output var npse_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus = '0;
  // Opening command, address bytes, optional closing command; never a cache read
  task automatic op(input logic [7:0] c, input int n, input logic [7:0] fin, input logic hit);
    bus <= '{1'b1, 1'b0, c, 1'b0};
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      bus <= '{1'b0, 1'b1, 8'(i), hit};
    end
    if (fin != 8'h00) begin
      @(posedge clk);
      bus <= '{1'b1, 1'b0, fin, 1'b0};
    end
    @(posedge clk);
    // Stale byte inverted so it never repeats a valid one
    bus <= '{1'b0, 1'b0, ~bus.data, 1'b0};
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the program-suspend and erase sequencer
`default_nettype none
module tb import npse_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  npse_bus_t bus;
  logic rdy, ardy, bvalid, rvalid, awready, wready, arready;
  logic [7:0] st, awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  int num_errors = 0;
  int cmp_count = 0;
  int busy_n;
  initial forever #50 clk = ~clk;
  npse_host host_u (.clk(clk), .bus(bus));
  npse_seq #(.PROG_CYC(400), .BERS_CYC(60)) dut_u (
    .clk(clk), .rst(rst), .bus(bus), .rdy_o(rdy), .ardy_o(ardy), .status_o(st),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready));
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    // An edge between calls, so no strobe is set twice in one step
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk(bresp, RESP_OKAY);
        return;
      end
    end
    num_errors++;
    give_verdict();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    num_errors++;
    give_verdict();
  endtask
  // Polls ready; a few quiet edges first so a late busy start is still seen
  task automatic busy();
    busy_n = 0;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (!(rdy === 1'b1 && ardy === 1'b1)) busy_n++;
      else if (i > 3) return;
    end
    num_errors++;
    give_verdict();
  endtask
  task automatic chk_busy(input int x);
    chk(40'(busy_n >= x - 2 && busy_n <= x + 2), 40'h1);
  endtask
  task automatic prog_susp();
    host_u.op(CMD_PROG, 5, CMD_CONF, 1'b1);
    repeat (3) @(posedge clk);
    host_u.op(CMD_SUSP, 5, 8'h00, 1'b1);
    busy();
  endtask
  task automatic s_regs();
    chk(st, 8'he0);
    axi_rd(STAT_OFS);
    chk({d[7:0], r}, {8'he0, RESP_OKAY});
    axi_rd(8'h0c);
    chk({d, r}, {32'h0, RESP_SLVERR});
  endtask
  task automatic s_erase();
    axi_wr(CTRL_OFS, 32'h2);
    host_u.op(CMD_ERASE, 3, CMD_ERASE_GO, 1'b1);
    busy();
    chk_busy(60);
    chk(st[SR_FAIL], 1'b1);
    host_u.op(CMD_ERASE, 3, CMD_ERASE_Q, 1'b1);
    busy();
    chk_busy(DBSY_CYC);
    axi_rd(PLANE_OFS);
    chk(d[7:0], 8'h01);
    host_u.op(CMD_ERASE, 3, CMD_ERASE_GO, 1'b1);
    busy();
    chk_busy(60);
    axi_rd(PLANE_OFS);
    chk(d[15:0], 16'h0100);
    axi_wr(CTRL_OFS, 32'h0);
  endtask
  task automatic s_susp();
    prog_susp();
    chk_busy(PSPD_CYC);
    chk(st, 8'he4);
    host_u.op(CMD_PROG_ALT, 5, CMD_CONF, 1'b1);
    busy();
    chk_busy(PSPDN_CYC);
    chk({st[SR_LOCK], st[SR_SUSP]}, 2'b01);
    host_u.op(CMD_ERASE, 3, CMD_ERASE_GO, 1'b1);
    busy();
    chk_busy(PSPDN_CYC);
    // Read here, then a program aimed at another LUN: suspension untouched
    for (int i = 0; i < 2; i++) begin
      host_u.op(i ? CMD_PROG : 8'h00, 5, i ? CMD_CONF : 8'h30, !i);
      busy();
      chk({busy_n, st}, {32'd0, 8'h64});
    end
    host_u.op(CMD_SUSP, 5, 8'h00, 1'b1);
    busy();
    chk_busy(PSPDN_CYC);
    chk(st[SR_SUSP], 1'b1);
    host_u.op(CMD_RES, 5, 8'h00, 1'b1);
    busy();
    chk(st[6:0], 7'h60);
  endtask
  task automatic s_idle();
    host_u.op(CMD_SUSP, 5, 8'h00, 1'b1);
    busy();
    chk(busy_n, 0);
    host_u.op(CMD_RES, 5, 8'h00, 1'b1);
    busy();
    chk_busy(PSPDN_CYC);
    host_u.op(CMD_PROG_ALT, 5, CMD_MPLANE, 1'b1);
    busy();
    chk_busy(DBSY_CYC);
  endtask
  // Suspend during a cache program waits for the array page
  task automatic s_cache();
    host_u.op(CMD_PROG, 5, CMD_CACHE, 1'b1);
    repeat (40) @(posedge clk);
    chk({rdy, ardy}, 2'b10);
    host_u.op(CMD_PROG, 5, CMD_CACHE, 1'b1);
    repeat (40) @(posedge clk);
    host_u.op(CMD_SUSP, 5, 8'h00, 1'b1);
    busy();
    chk(st, 8'he4);
    host_u.op(CMD_RES, 5, 8'h00, 1'b1);
    busy();
    chk(st, 8'he0);
  endtask
  task automatic s_rst();
    logic [7:0] rc [3] = '{CMD_RST_A, CMD_RST_B, CMD_RST_D};
    foreach (rc[i]) begin
      prog_susp();
      host_u.op(rc[i], 0, 8'h00, 1'b1);
      busy();
      chk(st, 8'he0);
    end
  endtask
  // OTP mode, then erase-suspended flag: both leave programs unsuspendable
  task automatic s_nosusp();
    for (int i = 0; i < 2; i++) begin
      axi_wr(CTRL_OFS, i ? 32'h4 : 32'h1);
      prog_susp();
      chk(st[SR_SUSP], 1'b0);
    end
    axi_wr(CTRL_OFS, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_erase();
    s_susp();
    s_idle();
    s_cache();
    s_rst();
    s_nosusp();
    give_verdict();
  end
endmodule
`default_nettype wire
